// *** include/tpmc_regs.vh ***
// Register map, mode codes and timing counts of the transceiver power control
`ifndef TPMC_REGS_VH
`define TPMC_REGS_VH
`define TPMC_ADDR_W 4
`define TPMC_OFS_MODE 4'h0
`define TPMC_OFS_STATUS 4'h1
`define TPMC_OFS_CFG 4'h2
`define TPMC_MODE_RESET 4'h0
`define TPMC_CFG_RESET 8'h01
`define TPMC_MODE_POWER_OFF 4'h0
`define TPMC_MODE_REGULATOR_NOMINAL 4'h4
`define TPMC_MODE_STANDBY 4'h5
`define TPMC_MODE_SYNTH_RECEIVE_SETTLE 4'h8
`define TPMC_MODE_RECEIVE_ACTIVE 4'h9
`define TPMC_MODE_SYNTH_TRANSMIT_SETTLE 4'hC
`define TPMC_MODE_TRANSMIT_ACTIVE 4'hD
`define TPMC_CLK_MHZ 250
`define TPMC_REG_RAMP_NS 400
`define TPMC_REG_RAMP_CYC ((`TPMC_REG_RAMP_NS * `TPMC_CLK_MHZ + 999) / 1000)
`define TPMC_ST_REG_UP 0
`define TPMC_ST_XTAL 1
`define TPMC_ST_SYNTH 2
`define TPMC_ST_SYNTH_TX 3
`define TPMC_ST_RX 4
`define TPMC_ST_TX 5
`define TPMC_ST_TX_LOCK 6
`define TPMC_ST_REG_READY 7
`endif

// *** src/tpmc_mode_decode.v ***
// Decoder from a mode code to the enables of the transceiver parts
`timescale 1ns/100ps
`include "tpmc_regs.vh"
module tpmc_mode_decode (
    input wire [3:0] mode,
    output reg reg_on,
    output reg xtal_on,
    output reg synth_on,
    output reg synth_tx,
    output reg rx_on,
    output reg tx_on
);
    always @* begin
        reg_on = 1'b0;
        xtal_on = 1'b0;
        synth_on = 1'b0;
        synth_tx = 1'b0;
        rx_on = 1'b0;
        tx_on = 1'b0;
        case (mode)
            `TPMC_MODE_REGULATOR_NOMINAL: begin
                reg_on = 1'b1;
            end
            `TPMC_MODE_STANDBY: begin
                reg_on = 1'b1;
                xtal_on = 1'b1;
            end
            `TPMC_MODE_SYNTH_RECEIVE_SETTLE: begin
                reg_on = 1'b1;
                xtal_on = 1'b1;
                synth_on = 1'b1;
            end
            `TPMC_MODE_RECEIVE_ACTIVE: begin
                reg_on = 1'b1;
                xtal_on = 1'b1;
                synth_on = 1'b1;
                rx_on = 1'b1;
            end
            `TPMC_MODE_SYNTH_TRANSMIT_SETTLE: begin
                reg_on = 1'b1;
                xtal_on = 1'b1;
                synth_on = 1'b1;
                synth_tx = 1'b1;
            end
            `TPMC_MODE_TRANSMIT_ACTIVE: begin
                reg_on = 1'b1;
                xtal_on = 1'b1;
                synth_on = 1'b1;
                synth_tx = 1'b1;
                tx_on = 1'b1;
            end
            default: begin
                reg_on = 1'b0;
            end
        endcase
    end
endmodule

// *** src/tpmc_sync3.v ***
// Three-stage synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
module tpmc_sync3 (
    input wire ref_clk,
    input wire srst,
    input wire din,
    output reg dout
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    always @(posedge ref_clk) begin
        if (srst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                dout <= s3_reg;
            end
        end
    end
endmodule

// *** src/tpmc_power_ctrl.v ***
// Transceiver power-mode controller with its register port
`timescale 1ns/100ps
`include "tpmc_regs.vh"
module tpmc_power_ctrl (
    input wire ref_clk,
    input wire srst,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire regulator_good,
    output reg transceiver_regulator_on,
    output reg xtal_enable,
    output reg synth_enable,
    output reg synth_tx_freq,
    output reg rx_enable,
    output reg tx_enable
);
    // Regulator sequencer states, one-hot
    localparam [2:0] RS_LOW = 3'h1;
    localparam [2:0] RS_RAMP = 3'h2;
    localparam [2:0] RS_UP = 3'h4;
    localparam integer RAMP_INT = `TPMC_REG_RAMP_CYC;
    localparam [8:0] RAMP_CYC = RAMP_INT[8:0];
    localparam [7:0] CFG_RESET = `TPMC_CFG_RESET;

    reg [3:0] transceiver_power_mode_reg;
    reg [3:0] eff_mode_reg;
    reg [3:0] eff_mode_next;
    reg tx_lock_reg;
    reg tx_lock_next;
    reg [8:0] ramp_cnt_reg;
    reg [8:0] ramp_cnt_next;
    reg [2:0] rstate_reg;
    reg [2:0] rstate_next;
    reg use_good_reg;
    reg [7:0] status;
    wire good_sync;
    wire d_reg_on;
    wire d_xtal;
    wire d_synth;
    wire d_synth_tx;
    wire d_rx;
    wire d_tx;
    wire reg_ready;

    tpmc_sync3 u_good_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .din(regulator_good),
        .dout(good_sync)
    );

    // Decodes the mode actually in force, not the written code
    tpmc_mode_decode u_decode (
        .mode(eff_mode_reg),
        .reg_on(d_reg_on),
        .xtal_on(d_xtal),
        .synth_on(d_synth),
        .synth_tx(d_synth_tx),
        .rx_on(d_rx),
        .tx_on(d_tx)
    );

    function is_lower_mode;
        input [3:0] m;
        begin
            is_lower_mode = (m != `TPMC_MODE_TRANSMIT_ACTIVE) &&
                (m != `TPMC_MODE_SYNTH_TRANSMIT_SETTLE);
        end
    endfunction

    function is_defined;
        input [3:0] m;
        begin
            case (m)
                `TPMC_MODE_POWER_OFF,
                `TPMC_MODE_REGULATOR_NOMINAL,
                `TPMC_MODE_STANDBY,
                `TPMC_MODE_SYNTH_RECEIVE_SETTLE,
                `TPMC_MODE_RECEIVE_ACTIVE,
                `TPMC_MODE_SYNTH_TRANSMIT_SETTLE,
                `TPMC_MODE_TRANSMIT_ACTIVE: is_defined = 1'b1;
                default: is_defined = 1'b0;
            endcase
        end
    endfunction

    // Ramp done once the timer elapsed and, if enabled, the monitor agrees
    assign reg_ready = (rstate_reg == RS_UP) &&
        (!use_good_reg || good_sync);

    // Mode and cfg registers, written only by software; cpu power state not seen
    always @(posedge ref_clk) begin
        if (srst) begin
            transceiver_power_mode_reg <= `TPMC_MODE_RESET;
            use_good_reg <= CFG_RESET[0];
        end else if (reg_wr) begin
            if (reg_addr == `TPMC_OFS_MODE) begin
                transceiver_power_mode_reg <= reg_wdata[3:0];
            end
            if (reg_addr == `TPMC_OFS_CFG) begin
                use_good_reg <= reg_wdata[0];
            end
        end
    end

    always @* begin
        eff_mode_next = transceiver_power_mode_reg;
        tx_lock_next = tx_lock_reg;
        if (!is_defined(transceiver_power_mode_reg)) begin
            eff_mode_next = `TPMC_MODE_POWER_OFF;
        end
        // Leaving full transmit: lower modes refused until synth tx
        if (eff_mode_reg == `TPMC_MODE_TRANSMIT_ACTIVE) begin
            tx_lock_next = 1'b1;
        end
        if (eff_mode_reg == `TPMC_MODE_SYNTH_TRANSMIT_SETTLE) begin
            tx_lock_next = 1'b0;
        end
        // Judged on the mode in force: the lock flag lags it by one edge
        if ((eff_mode_reg == `TPMC_MODE_TRANSMIT_ACTIVE) &&
            is_lower_mode(eff_mode_next)) begin
            eff_mode_next = eff_mode_reg;
        end
        // Full receive carries no lock, so power-down is direct
    end

    // Regulator sequencer; any drop of the request restarts the full ramp
    always @* begin
        rstate_next = rstate_reg;
        ramp_cnt_next = ramp_cnt_reg;
        case (rstate_reg)
            RS_LOW: begin
                ramp_cnt_next = RAMP_CYC;
                if (d_reg_on) begin
                    rstate_next = RS_RAMP;
                    ramp_cnt_next = RAMP_CYC - 9'h001;
                end
            end
            RS_RAMP: begin
                if (ramp_cnt_reg > 9'h001) begin
                    ramp_cnt_next = ramp_cnt_reg - 9'h001;
                end else begin
                    ramp_cnt_next = 9'h000;
                    rstate_next = RS_UP;
                end
            end
            RS_UP: begin
                ramp_cnt_next = 9'h000;
            end
            default: begin
                rstate_next = RS_LOW;
                ramp_cnt_next = RAMP_CYC;
            end
        endcase
        if (!d_reg_on) begin
            rstate_next = RS_LOW;
            ramp_cnt_next = RAMP_CYC;
        end
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            eff_mode_reg <= `TPMC_MODE_POWER_OFF;
            tx_lock_reg <= 1'b0;
            ramp_cnt_reg <= RAMP_CYC;
            rstate_reg <= RS_LOW;
        end else begin
            eff_mode_reg <= eff_mode_next;
            tx_lock_reg <= tx_lock_next;
            ramp_cnt_reg <= ramp_cnt_next;
            rstate_reg <= rstate_next;
        end
    end

    // Part enables; analog parts wait for the regulator to be ready
    always @(posedge ref_clk) begin
        if (srst) begin
            transceiver_regulator_on <= 1'b0;
            xtal_enable <= 1'b0;
            synth_enable <= 1'b0;
            synth_tx_freq <= 1'b0;
            rx_enable <= 1'b0;
            tx_enable <= 1'b0;
        end else begin
            transceiver_regulator_on <= d_reg_on;
            xtal_enable <= d_xtal && reg_ready;
            synth_enable <= d_synth && reg_ready;
            synth_tx_freq <= d_synth_tx && reg_ready;
            rx_enable <= d_rx && reg_ready;
            tx_enable <= d_tx && reg_ready;
        end
    end

    always @* begin
        status = 8'h00;
        status[`TPMC_ST_REG_UP] = transceiver_regulator_on;
        status[`TPMC_ST_XTAL] = xtal_enable;
        status[`TPMC_ST_SYNTH] = synth_enable;
        status[`TPMC_ST_SYNTH_TX] = synth_tx_freq;
        status[`TPMC_ST_RX] = rx_enable;
        status[`TPMC_ST_TX] = tx_enable;
        status[`TPMC_ST_TX_LOCK] = tx_lock_reg;
        status[`TPMC_ST_REG_READY] = reg_ready;
    end

    // Registers stay readable in every mode, power-down included
    always @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `TPMC_OFS_MODE: reg_rdata <= {4'h0,
                    transceiver_power_mode_reg};
                `TPMC_OFS_STATUS: reg_rdata <= status;
                `TPMC_OFS_CFG: reg_rdata <= {7'h00, use_good_reg};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule

// *** tb/tpmc_power_ctrl_props.sv ***
// Port assertions of the power-mode controller
`timescale 1ns/100ps
module tpmc_power_ctrl_props (
    input wire ref_clk,
    input wire srst,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire regulator_good,
    input wire transceiver_regulator_on,
    input wire xtal_enable,
    input wire synth_enable,
    input wire synth_tx_freq,
    input wire rx_enable,
    input wire tx_enable
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire mwr = reg_wr && reg_addr == 4'h0 && !tx_enable;
    wire [3:0] wm = reg_wdata[3:0];
    wire cwr = reg_wr && reg_addr == 4'h0 && reg_wdata[3:2] == 2'b11;
    a_parts_need_reg: assert property (!transceiver_regulator_on
        |-> !(xtal_enable || synth_enable || rx_enable || tx_enable))
        else $error("part on with regulator low");
    a_rx_tx_excl: assert property (!(rx_enable && tx_enable))
        else $error("rx and tx together");
    a_rx_synth: assert property (rx_enable
        |-> synth_enable && !synth_tx_freq) else $error("rx without synth");
    a_tx_synth: assert property (tx_enable
        |-> synth_enable && synth_tx_freq) else $error("tx without synth");
    a_reg_raise: assert property (mwr && wm == 4'h4
        |-> ##3 transceiver_regulator_on) else $error("regulator not up");
    a_power_off: assert property (mwr && wm == 4'h0
        |-> ##3 !transceiver_regulator_on) else $error("regulator not off");
    a_undef_off: assert property (mwr && wm == 4'h7
        |-> ##3 !transceiver_regulator_on) else $error("bad code not off");
    a_tx_lock: assert property (tx_enable && reg_wr
        && reg_addr == 4'h0 && reg_wdata[3:2] != 2'b11
        && !$past(cwr) && !$past(cwr, 2)
        |-> ##1 tx_enable [*3]) else $error("tx left early");
    a_ramp_wait: assert property ($rose(transceiver_regulator_on)
        |-> (!xtal_enable && !synth_enable) [*8]) else $error("no ramp");
    a_rdata_idle: assert property (!$past(reg_rd)
        |-> reg_rdata == 8'h00) else $error("read data not idle");
    c_rx: cover property (rx_enable);
    c_tx: cover property (tx_enable);
    c_refused: cover property (tx_enable && reg_wr && wm == 4'h0);
endmodule

// *** tb/tpmc_power_ctrl_test.sv ***
// Self-checking bench of the power-mode controller
`timescale 1ns/100ps
`include "tpmc_regs.vh"
module tpmc_power_ctrl_test;
    reg ref_clk = 1'b0;
    reg srst = 1'b1;
    reg [3:0] reg_addr = 4'h0;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg regulator_good = 1'b1;
    wire [7:0] reg_rdata;
    wire [5:0] outs;
    integer fail_count = 0;
    integer comparisons = 0;
    integer cycles = 0;
    always #2 ref_clk = ~ref_clk;
    tpmc_power_ctrl i_dut (.ref_clk(ref_clk), .srst(srst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .regulator_good(regulator_good),
        .transceiver_regulator_on(outs[5]), .xtal_enable(outs[4]),
        .synth_enable(outs[3]), .synth_tx_freq(outs[2]),
        .rx_enable(outs[1]), .tx_enable(outs[0]));
    function [5:0] parts(input [3:0] m);
        case (m)
            4'h4: parts = 6'b100000;
            4'h5: parts = 6'b110000;
            4'h8: parts = 6'b111000;
            4'h9: parts = 6'b111010;
            4'hC: parts = 6'b111100;
            4'hD: parts = 6'b111101;
            default: parts = 6'b000000;
        endcase
    endfunction
    task chk(input [8*6-1:0] name, input [7:0] seen, input [7:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("ERROR %0s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task rd(input [3:0] a, output [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
        @(posedge ref_clk);
    endtask
    // Write a code, let the ramp finish, compare parts and readback
    task step(input [3:0] code, input [3:0] eff);
        reg [7:0] d;
        wr(4'h0, {4'h0, code});
        repeat (120) @(posedge ref_clk); // Settling pause
        chk("parts", {2'b00, outs}, {2'b00, parts(eff)});
        rd(4'h0, d);
        chk("mode", d, {4'h0, code});
    endtask
    task test_reset;
        reg [7:0] d;
        chk("parts", {2'b00, outs}, 8'h00);
        rd(4'h0, d);
        chk("mode", d, 8'h00);
        rd(4'h2, d);
        chk("cfg", d, 8'h01);
        rd(4'h1, d);
        chk("stat", d, 8'h00);
    endtask
    task test_rx;
        step(4'h4, 4'h4);
        step(4'h5, 4'h5);
        step(4'h8, 4'h8);
        step(4'h9, 4'h9);
        step(4'h0, 4'h0);
    endtask
    task test_tx;
        reg [7:0] d;
        step(4'h5, 4'h5);
        step(4'hC, 4'hC);
        step(4'hD, 4'hD);
        step(4'h0, 4'hD);
        rd(4'h1, d);
        chk("lock", {7'h00, d[6]}, 8'h01);
        step(4'h5, 4'hD);
        step(4'hC, 4'hC);
        step(4'h0, 4'h0);
    endtask
    task test_map;
        reg [7:0] d;
        step(4'h4, 4'h4);
        step(4'h7, 4'h0);
        wr(4'h3, 8'h5A);
        rd(4'h3, d);
        chk("unmap", d, 8'h00);
    endtask
    // Parts wait for the regulator monitor unless cfg bit 0 is cleared
    task test_good;
        reg [7:0] d;
        regulator_good <= 1'b0;
        wr(4'h0, 8'h05);
        repeat (120) @(posedge ref_clk);
        chk("parts", {2'b00, outs}, {2'b00, parts(4'h4)});
        rd(4'h1, d);
        chk("stat", d, 8'h01);
        regulator_good <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk("parts", {2'b00, outs}, {2'b00, parts(4'h5)});
        rd(4'h1, d);
        chk("stat", d, 8'h83);
        wr(4'h0, 8'h00);
        regulator_good <= 1'b0;
        wr(4'h2, 8'h00);
        rd(4'h2, d);
        chk("cfg", d, 8'h00);
        step(4'h5, 4'h5);
        wr(4'h2, 8'h01);
        regulator_good <= 1'b1;
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count = fail_count + 1;
            conclude;
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        test_reset;
        test_rx;
        test_tx;
        test_map;
        test_good;
        conclude;
    end
endmodule
bind tpmc_power_ctrl tpmc_power_ctrl_props i_props (.ref_clk(ref_clk),
    .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .regulator_good(regulator_good),
    .transceiver_regulator_on(transceiver_regulator_on),
    .xtal_enable(xtal_enable), .synth_enable(synth_enable),
    .synth_tx_freq(synth_tx_freq), .rx_enable(rx_enable),
    .tx_enable(tx_enable));
